// ==== dv/nis_host_model.sv ====
// Host model: register port master reading the status block
`timescale 1ns/1ps
module nis_host_model
  import nis_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Drop last-byte fields when hard framing was flagged
  function automatic logic [7:0] lb_use(input logic hard, input logic [7:0] f2);
    return hard ? {f2[7:4], 4'h0} : f2;
  endfunction
endmodule // nis_host_model

// ==== dv/nis_status_tb.sv ====
// Testbench for the status block
`timescale 1ns/1ps
module nis_status_tb
  import nis_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, ew;
  logic reg_wr, reg_rd, err_pending, pt_pending;
  logic wt_irq_every = 1'b1;
  nis_err_ev_t err_ev = '0;
  nis_pt_ev_t pt_ev = '0;
  nis_fifo_t fifo_st = '0;
  int bad_count = 0;
  int num_checks = 0;
  // {timeout enable, events, expected flags}
  logic [15:0] rows [9] = '{16'hc080, 16'ha040, 16'h9020, 16'h8810, 16'h8408, 16'h8204, 16'h8102,
    16'h0400, 16'hfffe};
  always #2 clk = ~clk;
  nis_status dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_ev(err_ev), .pt_ev(pt_ev),
    .fifo_st(fifo_st), .wt_irq_every(wt_irq_every), .err_pending(err_pending), .pt_pending(pt_pending));
  nis_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic end_sim;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic ev_err(input nis_err_ev_t v);
    @(posedge clk);
    err_ev <= v;
    @(posedge clk);
    err_ev <= '0;
  endtask
  task automatic ev_pt(input logic [11:0] v);
    @(posedge clk);
    pt_ev <= v;
    @(posedge clk);
    pt_ev <= nis_pt_ev_t'(v & 12'h78f);
  endtask
  initial
  begin
    #20000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(NIS_OFS_ERR_WAKE, 8'h00);
    rdchk(NIS_OFS_PT_FLAGS, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      wt_irq_every <= rows[i][15];
      ev_err(rows[i][14:8]);
      rdchk(NIS_OFS_ERR_WAKE, rows[i][7:0]);
      rdchk(NIS_OFS_MAIN_IRQ, 8'h00);
      rdchk(NIS_OFS_ERR_WAKE, 8'h00);
    end
    ev_err(7'h40);
    #1;
    chk("err_pending", 8'h01, {7'h00, err_pending});
    host_u.wr(NIS_OFS_ERR_WAKE, 8'hff);
    rdchk(NIS_OFS_ERR_WAKE, 8'h80);
    fork
      rdchk(NIS_OFS_MAIN_IRQ, 8'h00);
      ev_err(7'h20);
    join
    rdchk(NIS_OFS_ERR_WAKE, 8'h40);
    ev_pt(12'h280);
    ev_pt(12'h270);
    ev_pt(12'ha05);
    ev_pt(12'h20d);
    #1;
    chk("pt_pending", 8'h01, {7'h00, pt_pending});
    rdchk(NIS_OFS_PT_FLAGS, 8'hfb);
    rdchk(NIS_OFS_PT_FLAGS, 8'h00);
    @(posedge clk);
    fifo_st <= {10'h200, 1'b1, 1'b0, 3'h5, 1'b1};
    rdchk(NIS_OFS_FIFO_LO, 8'h00);
    rdchk(NIS_OFS_FIFO_HI, 8'hab);
    ev_err(7'h08);
    host_u.rd(NIS_OFS_ERR_WAKE, ew);
    host_u.rd(NIS_OFS_FIFO_HI, d);
    chk("fifo_hi_host", 8'ha0, host_u.lb_use(ew[NIS_EW_HARD], d));
    @(posedge clk);
    fifo_st <= {10'h155, 1'b0, 1'b1, 3'h0, 1'b0};
    rdchk(NIS_OFS_FIFO_LO, 8'h55);
    rdchk(NIS_OFS_FIFO_HI, 8'h50);
    rdchk(8'h30, 8'h00);
    ev_err(7'h01);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(NIS_OFS_ERR_WAKE, 8'h00);
    rdchk(NIS_OFS_PT_FLAGS, 8'h00);
    end_sim;
  end
endmodule // nis_status_tb

// ==== hdl/nis_pkg.sv ====
// Package: register map, field positions and event carriers of the status block
package nis_pkg;

  // Register offsets
  localparam logic [7:0] NIS_OFS_MAIN_IRQ = 8'h1a;
  localparam logic [7:0] NIS_OFS_ERR_WAKE = 8'h1c;
  localparam logic [7:0] NIS_OFS_PT_FLAGS = 8'h1d;
  localparam logic [7:0] NIS_OFS_FIFO_LO = 8'h1e;
  localparam logic [7:0] NIS_OFS_FIFO_HI = 8'h1f;

  // Error and wake-up flag positions
  localparam int NIS_EW_CRC = 7;
  localparam int NIS_EW_PAR = 6;
  localparam int NIS_EW_SOFT = 5;
  localparam int NIS_EW_HARD = 4;
  localparam int NIS_EW_WT = 3;
  localparam int NIS_EW_AMP = 2;
  localparam int NIS_EW_PHS = 1;

  // Passive target flag positions
  localparam int NIS_PT_PPON2 = 7;
  localparam int NIS_PT_SLWL = 6;
  localparam int NIS_PT_APON = 5;
  localparam int NIS_PT_RXE = 4;
  localparam int NIS_PT_WUF = 3;
  localparam int NIS_PT_WUAS = 1;
  localparam int NIS_PT_WUA = 0;

  // Second FIFO status field positions
  localparam int NIS_F2_CNT_HI = 6;
  localparam int NIS_F2_UNF = 5;
  localparam int NIS_F2_OVR = 4;
  localparam int NIS_F2_LB = 1;
  localparam int NIS_F2_NP = 0;

  // Reset values and limits
  localparam logic [7:0] NIS_FLAGS_RST = 8'h00;
  localparam logic [7:0] NIS_EW_VALID = 8'hfe;
  localparam logic [7:0] NIS_PT_VALID = 8'hfb;
  localparam logic [9:0] NIS_FIFO_MAX = 10'h200;
  localparam logic [3:0] NIS_SLOT_WL = 4'h4;

  // Error and wake-up events, one-cycle pulses
  typedef struct packed {
    logic crc_err;
    logic parity_err;
    logic soft_framing;
    logic hard_framing;
    logic wakeup_timeout;
    logic amp_over_ref;
    logic phase_over_ref;
  } nis_err_ev_t;

  // Passive target events, one-cycle pulses except the free_slots and pta_state levels
  typedef struct packed {
    logic ppon2_timer;
    logic [3:0] free_slots;
    logic apon_no_coll;
    logic rx_end_auto;
    logic sensf_resp_sent;
    logic [3:0] pta_state;
  } nis_pt_ev_t;

  // FIFO state as seen by the status view
  typedef struct packed {
    logic [9:0] byte_count;
    logic underflow;
    logic overflow;
    logic [2:0] last_bits;
    logic no_parity;
  } nis_fifo_t;

  // ISO-A passive target state codes
  typedef enum logic [3:0] {
    NIS_PTA_OFF = 4'b0000,
    NIS_PTA_IDLE = 4'b0001,
    NIS_PTA_RDY1 = 4'b0010,
    NIS_PTA_RDY2 = 4'b0011,
    NIS_PTA_ACT = 4'b0101,
    NIS_PTA_HALT = 4'b1001,
    NIS_PTA_RDY1S = 4'b1010,
    NIS_PTA_RDY2S = 4'b1011,
    NIS_PTA_ACTS = 4'b1101
  } nis_pta_t;

endpackage

// ==== hdl/nis_status.sv ====
// Error, wake-up and passive target flags with FIFO status view
// Function
// R1: Bits 7/6 flag CRC and parity errors
// R2: Bit 5 flags soft framing error
// R3: Bit 4 flags hard framing error
// R4: Bit 3 on wake-up timeout if selected
// R5: Bit 2 on amplitude above reference
// R6: Bit 1 on phase above reference
// R7: Main register read clears error/wake flags
// R8: Passive bit 7 on second field-on timer
// R9: Passive bit 6 when four slots remain
// R10: Passive bit 5 after field switched on
// R11: Passive bit 4 at automatic answer receive end
// R12: Passive bit 3 after SENSF response sent
// R13: Passive bit 1 on entering starred active
// R14: Passive bit 0 on entering active
// R15: Reading passive register clears its flags
// R16: Ten-bit byte count split over two registers
// R17: FIFO underflow bit 5, overflow bit 4
// R18: Bits 3..1 give last byte bit count
// R19: Bit 0 marks missing parity
// R20: Host ignores last-byte fields on hard framing
// R21: Reserved bits read zero, writes ignored
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module nis_status
  import nis_pkg::*;
#(
  parameter int CNT_W = 10
)(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event sources
  input wire nis_err_ev_t err_ev,
  input wire nis_pt_ev_t pt_ev,
  input wire nis_fifo_t fifo_st,
  input wire logic wt_irq_every,
  // Flag view for the main interrupt logic
  output logic err_pending,
  output logic pt_pending
);

  // Refuse any count width other than the ten bits the register split carries
  if (CNT_W != 10)
  begin : g_cnt_w_check
    $error("nis_status: byte count width must be 10");
  end

  logic [7:0] err_ff;
  logic [7:0] pt_ff;
  logic [7:0] rdata_ff;
  logic [3:0] pta_prev_ff;
  logic [3:0] slots_prev_ff;
  logic [7:0] nxt_err_set;
  logic [7:0] nxt_pt_set;
  logic rd_main;
  logic rd_pt;
  logic enter_act;
  logic enter_acts;
  logic slot_hit;

  assign rd_main = reg_rd && (reg_addr == NIS_OFS_MAIN_IRQ);
  assign rd_pt = reg_rd && (reg_addr == NIS_OFS_PT_FLAGS);
  assign enter_act = (pt_ev.pta_state == NIS_PTA_ACT) && (pta_prev_ff != NIS_PTA_ACT);
  assign enter_acts = (pt_ev.pta_state == NIS_PTA_ACTS) && (pta_prev_ff != NIS_PTA_ACTS);
  assign slot_hit = (pt_ev.free_slots == NIS_SLOT_WL) && (slots_prev_ff != NIS_SLOT_WL);

  // Event set vectors
  always_comb
  begin
    nxt_err_set = NIS_FLAGS_RST;
    nxt_err_set[NIS_EW_CRC] = err_ev.crc_err; // see R1
    nxt_err_set[NIS_EW_PAR] = err_ev.parity_err; // see R1
    nxt_err_set[NIS_EW_SOFT] = err_ev.soft_framing; // see R2
    nxt_err_set[NIS_EW_HARD] = err_ev.hard_framing; // see R3
    nxt_err_set[NIS_EW_WT] = err_ev.wakeup_timeout && wt_irq_every; // see R4
    nxt_err_set[NIS_EW_AMP] = err_ev.amp_over_ref; // see R5
    nxt_err_set[NIS_EW_PHS] = err_ev.phase_over_ref; // see R6
    nxt_pt_set = NIS_FLAGS_RST;
    nxt_pt_set[NIS_PT_PPON2] = pt_ev.ppon2_timer; // see R8
    nxt_pt_set[NIS_PT_SLWL] = slot_hit; // see R9
    nxt_pt_set[NIS_PT_APON] = pt_ev.apon_no_coll; // see R10
    nxt_pt_set[NIS_PT_RXE] = pt_ev.rx_end_auto; // see R11
    nxt_pt_set[NIS_PT_WUF] = pt_ev.sensf_resp_sent; // see R12
    nxt_pt_set[NIS_PT_WUAS] = enter_acts; // see R13
    nxt_pt_set[NIS_PT_WUA] = enter_act; // see R14
  end

  // State history for edge events
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Track levels in reset so release shows no false entry
      pta_prev_ff <= pt_ev.pta_state;
      slots_prev_ff <= pt_ev.free_slots;
    end
    else
    begin
      pta_prev_ff <= pt_ev.pta_state;
      slots_prev_ff <= pt_ev.free_slots;
    end
  end

  // Error and wake-up flags, set wins over clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      err_ff <= NIS_FLAGS_RST;
    else if (rd_main)
      err_ff <= nxt_err_set & NIS_EW_VALID; // see R7 R21
    else
      err_ff <= (err_ff | nxt_err_set) & NIS_EW_VALID; // see R21
  end

  // Passive target flags, set wins over clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pt_ff <= NIS_FLAGS_RST;
    else if (rd_pt)
      pt_ff <= nxt_pt_set & NIS_PT_VALID; // see R15 R21
    else
      pt_ff <= (pt_ff | nxt_pt_set) & NIS_PT_VALID; // see R21
  end

  // Read data, one cycle after the strobe; writes change nothing here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        NIS_OFS_ERR_WAKE: rdata_ff <= err_ff;
        NIS_OFS_PT_FLAGS: rdata_ff <= pt_ff;
        NIS_OFS_FIFO_LO: rdata_ff <= fifo_st.byte_count[7:0]; // see R16
        NIS_OFS_FIFO_HI: rdata_ff <= {fifo_st.byte_count[9:8], // see R16
                                      fifo_st.underflow, fifo_st.overflow, // see R17
                                      fifo_st.last_bits, // see R18
                                      fifo_st.no_parity}; // see R19
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata = rdata_ff;
  assign err_pending = |err_ff;
  assign pt_pending = |pt_ff;

  // Assertions
  sequence main_rd_s;
    rd_main && !(|nxt_err_set);
  endsequence

  err_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see R7
    main_rd_s |=> (err_ff == 8'h00)) else $error("error flags not cleared");
  pt_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see R15
    rd_pt && !(|nxt_pt_set) |=> (pt_ff == 8'h00)) else $error("passive flags not cleared");
  crc_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    err_ev.crc_err |=> err_ff[7]) else $error("crc flag missed");
  hard_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see R3
    err_ev.hard_framing ##1 !rd_main |=> err_ff[4]) else $error("hard framing flag lost");
  wt_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // see R4
    !err_ff[3] && !(err_ev.wakeup_timeout && wt_irq_every) |=> !err_ff[3])
    else $error("wake-up timer flag without cause");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // see R21
    !err_ff[0] && !pt_ff[2]) else $error("reserved bit set");
  act_enter_a: assert property (@(posedge clk) disable iff (sys_rst) // see R14
    $changed(pt_ev.pta_state) && pt_ev.pta_state == NIS_PTA_ACT |=> pt_ff[0])
    else $error("active flag missed");
  slot_wl_a: assert property (@(posedge clk) disable iff (sys_rst) // see R9
    slot_hit |=> pt_ff[6]) else $error("slot water level flag missed");
  fifo_hi_a: assert property (@(posedge clk) disable iff (sys_rst) // see R16
    reg_rd && reg_addr == NIS_OFS_FIFO_HI |=> reg_rdata[7:6] == $past(fifo_st.byte_count[9:8]))
    else $error("count high bits wrong");
  fifo_lo_a: assert property (@(posedge clk) disable iff (sys_rst) // see R16
    reg_rd && reg_addr == NIS_OFS_FIFO_LO |=> reg_rdata == $past(fifo_st.byte_count[7:0]))
    else $error("count low bits wrong");
  unf_ovr_a: assert property (@(posedge clk) disable iff (sys_rst) // see R17
    reg_rd && reg_addr == NIS_OFS_FIFO_HI |=> reg_rdata[5:4] == {$past(fifo_st.underflow),
    $past(fifo_st.overflow)}) else $error("fifo error bits wrong");
  par_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    err_ev.parity_err |=> err_ff[NIS_EW_PAR]) else $error("parity flag missed");
  soft_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R2
    err_ev.soft_framing |=> err_ff[NIS_EW_SOFT]) else $error("soft framing flag missed");
  wt_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R4
    err_ev.wakeup_timeout && wt_irq_every |=> err_ff[NIS_EW_WT]) else $error("wake-up timer flag missed");
  amp_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R5
    err_ev.amp_over_ref |=> err_ff[NIS_EW_AMP]) else $error("amplitude flag missed");
  phs_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R6
    err_ev.phase_over_ref |=> err_ff[NIS_EW_PHS]) else $error("phase flag missed");
  ppon2_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R8
    pt_ev.ppon2_timer |=> pt_ff[NIS_PT_PPON2]) else $error("field-on wait flag missed");
  apon_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R10
    pt_ev.apon_no_coll |=> pt_ff[NIS_PT_APON]) else $error("field-on flag missed");
  rxe_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R11
    pt_ev.rx_end_auto |=> pt_ff[NIS_PT_RXE]) else $error("receive end flag missed");
  wuf_set_a: assert property (@(posedge clk) disable iff (sys_rst) // see R12
    pt_ev.sensf_resp_sent |=> pt_ff[NIS_PT_WUF]) else $error("response sent flag missed");
  acts_enter_a: assert property (@(posedge clk) disable iff (sys_rst) // see R13
    $changed(pt_ev.pta_state) && pt_ev.pta_state == NIS_PTA_ACTS |=> pt_ff[NIS_PT_WUAS])
    else $error("starred active flag missed");
  last_byte_a: assert property (@(posedge clk) disable iff (sys_rst) // see R18 R19
    reg_rd && reg_addr == NIS_OFS_FIFO_HI |=> reg_rdata[3:0] == {$past(fifo_st.last_bits),
    $past(fifo_st.no_parity)}) else $error("last byte fields wrong");
  wr_ignore_a: assert property (@(posedge clk) disable iff (sys_rst) // see R21
    reg_wr && !reg_rd && (reg_wdata != 8'h00) && !(|nxt_pt_set) |=> pt_ff == $past(pt_ff))
    else $error("write changed passive flags");

endmodule // nis_status
